// >>> lssd_pkg.sv
package lssd_pkg;

   // ----------------------------------------------------------------
   // input function codes
   // ----------------------------------------------------------------
   localparam logic [7:0] FC_NOMINAL = 8'h50;  // 80
   localparam logic [7:0] FC_INTERM = 8'h51;  // 81
   localparam logic [7:0] FC_RELEVEL = 8'h52;  // 82
   localparam logic [7:0] FC_LEVELING = 8'h53;  // 83
   localparam logic [7:0] FC_INSPECT = 8'h54;  // 84

   // factory default assignment of the four terminals
   localparam logic [7:0] FC_DEF_IN1 = FC_NOMINAL;
   localparam logic [7:0] FC_DEF_IN2 = FC_INSPECT;
   localparam logic [7:0] FC_DEF_IN3 = FC_INTERM;
   localparam logic [7:0] FC_DEF_IN4 = FC_LEVELING;

   // priority modes
   localparam logic [1:0] MODE_HIGH_PRIO = 2'h1;
   localparam logic [1:0] MODE_LEVEL_PRIO = 2'h2;
   localparam logic [1:0] MODE_DEFAULT = MODE_HIGH_PRIO;
   localparam logic REF_LOSS_DEFAULT = 1'h1;

   // ----------------------------------------------------------------
   // register map (apb byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_FUNC = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

   // config field positions
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_REFLOSS_BIT = 4;

   // interrupt event bits
   localparam int IRQ_FAULT_BIT = 0;
   localparam int IRQ_STOP_BIT = 1;
   localparam int IRQ_DECEL_BIT = 2;
   localparam int IRQ_W = 3;

   // speed selection result
   typedef enum logic [2:0] {
      LSSD_SPD_ZERO,
      LSSD_SPD_NOMINAL,
      LSSD_SPD_INTERM1,
      LSSD_SPD_INTERM2,
      LSSD_SPD_INTERM3,
      LSSD_SPD_RELEVEL,
      LSSD_SPD_LEVELING
   } lssd_speed_type;

   // decoded speed commands
   typedef struct packed {
      logic nominal;
      logic interm;
      logic relevel;
      logic leveling;
      logic inspect;
   } lssd_cmd_type;

   // which functions are assigned to any terminal
   typedef struct packed {
      logic nominal;
      logic leveling;
   } lssd_assign_type;

endpackage : lssd_pkg

// >>> lssd_decoder.sv
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
// Contract
// - default terminals: nominal, inspection, intermediate, leveling
// - high prio with leveling: decel to leveling
// - high prio ignores leveling while higher selected
// - high prio never picks inspection speed
// - high prio, leveling: stop on leveling/direction loss
// - decode table for travel speed combinations
// - no leveling input: drop decels to leveling
// - no leveling input: stop only on direction
// - no leveling input: no input selected gives leveling speed
// - reference loss fault at start, enable gated
// - level prio: leveling overrides travel speed
// - level prio: stop when leveling removed
// - no nominal input: no speed input selected gives nominal
// - no nominal input: stop on leveling/direction loss
// - no nominal input: intermediate 2 unreachable
// - reference loss enable one bit, default on
module lssd_decoder (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // lift controller inputs
   input wire logic [3:0] input_terminal_i,
   input wire logic up_dir_i,
   input wire logic down_dir_i,
   // drive outputs
   output lssd_pkg::lssd_speed_type speed_sel_o,
   output logic run_o,
   output logic reference_loss_fault_o,
   output logic irq_o
);

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   logic [1:0] speed_priority_mode;
   logic ref_loss_detect_enable;
   logic [7:0] input1_function_code;
   logic [7:0] input2_function_code;
   logic [7:0] input3_function_code;
   logic [7:0] input4_function_code;
   logic [lssd_pkg::IRQ_W-1:0] irq_stat;
   logic [lssd_pkg::IRQ_W-1:0] irq_mask;

   logic wr_en;
   assign wr_en = psel_i & penable_i & pwrite_i;

   // config writes; defaults give the factory terminal map
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         speed_priority_mode <= lssd_pkg::MODE_DEFAULT;
         ref_loss_detect_enable <= lssd_pkg::REF_LOSS_DEFAULT;
         input1_function_code <= lssd_pkg::FC_DEF_IN1;
         input2_function_code <= lssd_pkg::FC_DEF_IN2;
         input3_function_code <= lssd_pkg::FC_DEF_IN3;
         input4_function_code <= lssd_pkg::FC_DEF_IN4;
      end else if (wr_en) begin
         if (paddr_i == lssd_pkg::ADDR_CONFIG) begin
            speed_priority_mode <= pwdata_i[lssd_pkg::CFG_MODE_LSB +: 2];
            ref_loss_detect_enable <= pwdata_i[lssd_pkg::CFG_REFLOSS_BIT];
         end
         if (paddr_i == lssd_pkg::ADDR_FUNC) begin
            input1_function_code <= pwdata_i[7:0];
            input2_function_code <= pwdata_i[15:8];
            input3_function_code <= pwdata_i[23:16];
            input4_function_code <= pwdata_i[31:24];
         end
      end
   end

   // ----------------------------------------------------------------
   // input decode
   // ----------------------------------------------------------------
   // or together every terminal carrying a given function code
   function automatic logic func_active(input logic [3:0] term, input logic [31:0] codes,
                                        input logic [7:0] fc);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 4; i++) begin
         if (codes[8*i +: 8] == fc && term[i]) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   // true when some terminal carries the function code
   function automatic logic func_assigned(input logic [31:0] codes, input logic [7:0] fc);
      return func_active(4'hf, codes, fc);
   endfunction

   logic [31:0] codes;
   lssd_pkg::lssd_cmd_type cmd;
   lssd_pkg::lssd_assign_type asg;
   logic dir_on;
   assign codes = {input4_function_code, input3_function_code,
                   input2_function_code, input1_function_code};
   assign cmd.nominal = func_active(input_terminal_i, codes, lssd_pkg::FC_NOMINAL);
   assign cmd.interm = func_active(input_terminal_i, codes, lssd_pkg::FC_INTERM);
   assign cmd.relevel = func_active(input_terminal_i, codes, lssd_pkg::FC_RELEVEL);
   assign cmd.leveling = func_active(input_terminal_i, codes, lssd_pkg::FC_LEVELING);
   assign cmd.inspect = func_active(input_terminal_i, codes, lssd_pkg::FC_INSPECT);
   assign asg.nominal = func_assigned(codes, lssd_pkg::FC_NOMINAL);
   assign asg.leveling = func_assigned(codes, lssd_pkg::FC_LEVELING);
   assign dir_on = up_dir_i ^ down_dir_i;  // both at once is no valid direction

   // travel speed from nominal/intermediate/releveling bits
   function automatic lssd_pkg::lssd_speed_type travel(input logic n, input logic i,
                                                       input logic r);
      lssd_pkg::lssd_speed_type s;
      s = lssd_pkg::LSSD_SPD_ZERO;
      case ({n, i, r})
         3'h4: s = lssd_pkg::LSSD_SPD_NOMINAL;
         3'h2: s = lssd_pkg::LSSD_SPD_INTERM1;
         3'h6: s = lssd_pkg::LSSD_SPD_INTERM2;
         3'h3: s = lssd_pkg::LSSD_SPD_INTERM3;
         3'h1: s = lssd_pkg::LSSD_SPD_RELEVEL;
         default: s = lssd_pkg::LSSD_SPD_ZERO;
      endcase
      return s;
   endfunction

   // ----------------------------------------------------------------
   // speed selection, re-evaluated every cycle
   // ----------------------------------------------------------------
   lssd_pkg::lssd_speed_type next_speed;
   logic any_travel;
   logic keep_run;
   logic n_eff;
   logic lvl_prev;
   // inspection input never enters the travel decode
   assign n_eff = asg.nominal ? cmd.nominal : 1'b0;
   assign any_travel = cmd.nominal | cmd.interm | cmd.relevel;

   always_comb begin
      next_speed = lssd_pkg::LSSD_SPD_ZERO;
      keep_run = 1'b0;
      if (speed_priority_mode == lssd_pkg::MODE_LEVEL_PRIO) begin
         if (asg.nominal) begin
            // leveling overrides travel speed
            if (cmd.leveling) begin
               next_speed = lssd_pkg::LSSD_SPD_LEVELING;
            end else begin
               next_speed = travel(n_eff, cmd.interm, cmd.relevel);
            end
            // only the falling edge of leveling or loss of direction ends the run; travel alone keeps it
            keep_run = dir_on & ~(asg.leveling & lvl_prev & ~cmd.leveling);
         end else begin
            // no nominal input: no speed selection at all means nominal
            if (cmd.leveling) begin
               next_speed = lssd_pkg::LSSD_SPD_LEVELING;
            end else if (cmd.interm & cmd.relevel) begin
               next_speed = lssd_pkg::LSSD_SPD_INTERM3;
            end else if (cmd.interm) begin
               next_speed = lssd_pkg::LSSD_SPD_INTERM1;
            end else if (cmd.relevel) begin
               next_speed = lssd_pkg::LSSD_SPD_RELEVEL;
            end else begin
               next_speed = lssd_pkg::LSSD_SPD_NOMINAL;
            end
            keep_run = dir_on & ~(lvl_prev & ~cmd.leveling);
         end
      end else begin
         // higher speed priority; inspection is never a travel speed
         if (any_travel) begin
            next_speed = travel(cmd.nominal, cmd.interm, cmd.relevel);
         end else if (asg.leveling) begin
            next_speed = cmd.leveling ? lssd_pkg::LSSD_SPD_LEVELING
                                      : lssd_pkg::LSSD_SPD_ZERO;
         end else begin
            next_speed = lssd_pkg::LSSD_SPD_LEVELING;
         end
         if (asg.leveling) begin
            keep_run = dir_on & (cmd.leveling | any_travel);
         end else begin
            keep_run = dir_on;
         end
      end
   end

   // ----------------------------------------------------------------
   // run sequencing and reference loss
   // ----------------------------------------------------------------
   logic start_req;
   logic loss_now;
   logic run_ok;
   logic stop_hold;
   assign start_req = dir_on & ~run_o & ~reference_loss_fault_o & ~stop_hold;
   // the check only exists outside level priority mode, without a leveling input
   assign loss_now = start_req & ref_loss_detect_enable & ~any_travel
                   & (speed_priority_mode != lssd_pkg::MODE_LEVEL_PRIO) & ~asg.leveling;
   // in level priority a start needs a travel speed or leveling, stop tracks leveling
   assign run_ok = (speed_priority_mode == lssd_pkg::MODE_LEVEL_PRIO) ?
                   (any_travel | cmd.leveling) : 1'b1;

   // run flag and latched fault; fault clears when direction is removed
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         run_o <= 1'b0;
         reference_loss_fault_o <= 1'b0;
         lvl_prev <= 1'b0;
         stop_hold <= 1'b0;
      end else begin
         lvl_prev <= cmd.leveling;
         // a stopped run restarts only after direction drops, else it would chatter
         stop_hold <= dir_on & (stop_hold | (run_o & ~keep_run));
         if (loss_now) begin
            reference_loss_fault_o <= 1'b1;
         end else if (!dir_on) begin
            reference_loss_fault_o <= 1'b0;
         end
         if (run_o) begin
            run_o <= keep_run;
         end else begin
            run_o <= start_req & ~loss_now & run_ok;
         end
      end
   end

   // registered speed output, follows next_speed also when not running
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         speed_sel_o <= lssd_pkg::LSSD_SPD_ZERO;
      end else begin
         speed_sel_o <= next_speed;
      end
   end

   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------
   logic [lssd_pkg::IRQ_W-1:0] ev;
   assign ev[lssd_pkg::IRQ_FAULT_BIT] = loss_now;
   assign ev[lssd_pkg::IRQ_STOP_BIT] = run_o & ~keep_run;
   assign ev[lssd_pkg::IRQ_DECEL_BIT] = run_o & (next_speed == lssd_pkg::LSSD_SPD_LEVELING)
                                      & (speed_sel_o != lssd_pkg::LSSD_SPD_LEVELING);

   // sticky status: a new event wins over a write-one clear
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_stat <= '0;
         irq_mask <= '0;
      end else begin
         if (wr_en && paddr_i == lssd_pkg::ADDR_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~pwdata_i[lssd_pkg::IRQ_W-1:0]) | ev;
         end else begin
            irq_stat <= irq_stat | ev;
         end
         if (wr_en && paddr_i == lssd_pkg::ADDR_IRQ_MASK) begin
            irq_mask <= pwdata_i[lssd_pkg::IRQ_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat & irq_mask);
      end
   end

   // ----------------------------------------------------------------
   // apb read path: data prepared in setup, ready in access
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prdata_o <= '0;
         pslverr_o <= 1'b0;
         pready_o <= 1'b0;
      end else begin
         pready_o <= psel_i & ~penable_i;  // one wait-free access cycle
         if (psel_i && !penable_i) begin
            pslverr_o <= 1'b0;
            prdata_o <= '0;
            case (paddr_i)
               lssd_pkg::ADDR_CONFIG: begin
                  prdata_o[lssd_pkg::CFG_MODE_LSB +: 2] <= speed_priority_mode;
                  prdata_o[lssd_pkg::CFG_REFLOSS_BIT] <= ref_loss_detect_enable;
               end
               lssd_pkg::ADDR_FUNC: begin
                  prdata_o <= codes;
               end
               lssd_pkg::ADDR_STATUS: begin
                  prdata_o[2:0] <= speed_sel_o;
                  prdata_o[4] <= run_o;
                  prdata_o[5] <= reference_loss_fault_o;
               end
               lssd_pkg::ADDR_IRQ_STAT: begin
                  prdata_o[lssd_pkg::IRQ_W-1:0] <= irq_stat;
               end
               lssd_pkg::ADDR_IRQ_MASK: begin
                  prdata_o[lssd_pkg::IRQ_W-1:0] <= irq_mask;
               end
               default: begin
                  pslverr_o <= 1'b1;  // unmapped address
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_hp_inspect_never: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (speed_priority_mode == lssd_pkg::MODE_HIGH_PRIO && cmd.inspect && !any_travel
       && !asg.leveling) |=> speed_sel_o == lssd_pkg::LSSD_SPD_LEVELING)
      else $error("inspection chosen as travel speed");
   chk_lp_level_override: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (speed_priority_mode == lssd_pkg::MODE_LEVEL_PRIO && cmd.leveling)
      |=> speed_sel_o == lssd_pkg::LSSD_SPD_LEVELING)
      else $error("leveling did not override");
   chk_hp_level_ignored: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (speed_priority_mode == lssd_pkg::MODE_HIGH_PRIO && cmd.nominal && !cmd.interm
       && !cmd.relevel) |=> speed_sel_o == lssd_pkg::LSSD_SPD_NOMINAL)
      else $error("higher speed lost priority");
   chk_hp_no_input_level: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (speed_priority_mode == lssd_pkg::MODE_HIGH_PRIO && !asg.leveling && !any_travel)
      |=> speed_sel_o == lssd_pkg::LSSD_SPD_LEVELING)
      else $error("no input did not give leveling");
   chk_loss_fault_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      loss_now |=> reference_loss_fault_o && !run_o)
      else $error("reference loss not flagged");
   chk_loss_fault_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (!ref_loss_detect_enable && !reference_loss_fault_o) |=> !$rose(reference_loss_fault_o))
      else $error("fault raised while disabled");
   chk_dir_stop_run: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (run_o && !dir_on) |=> !run_o)
      else $error("run kept without direction");
   chk_lp_stop_level: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (run_o && speed_priority_mode == lssd_pkg::MODE_LEVEL_PRIO && !asg.nominal
       && lvl_prev && !cmd.leveling) |=> !run_o)
      else $error("run kept after leveling removed");
   chk_lp_no_interm2: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (speed_priority_mode == lssd_pkg::MODE_LEVEL_PRIO && !asg.nominal)
      |=> speed_sel_o != lssd_pkg::LSSD_SPD_INTERM2)
      else $error("intermediate 2 reached");

endmodule // lssd_decoder

// >>> lssd_lift_ctrl.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// lift controller model driving terminals and direction
// ----------------------------------------------------------------
module lssd_lift_ctrl (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // commands from the bench
   input wire logic [3:0] want_terms_i,
   input wire logic [1:0] want_dir_i,
   input wire logic [3:0] insp_terms_i,
   input wire logic level_prio_i,
   input wire logic slow_i,
   // lines into the drive
   output logic [3:0] input_terminal_o,
   output logic up_dir_o,
   output logic down_dir_o
);
   logic [5:0] lag1;
   logic [5:0] lag2;
   // inspection never used as travel speed under leveling priority
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lag1 <= 6'h00;
         lag2 <= 6'h00;
      end else begin
         lag1 <= {want_dir_i, want_terms_i & ~(level_prio_i ? insp_terms_i : 4'h0)};
         lag2 <= lag1;
      end
   end
   // second stage models a slow relay path in the controller
   assign {down_dir_o, up_dir_o, input_terminal_o} = slow_i ? lag2 : lag1;
endmodule // lssd_lift_ctrl

// >>> lssd_decoder_tb_top.sv
`timescale 1ns/1ps
module lssd_decoder_tb_top;
   // ----------------------------------------------------------------
   // signals and tables
   // ----------------------------------------------------------------
   localparam logic [31:0] CODES [3] = '{32'h53525150, 32'h54525150, 32'h53525154};
   // rows: mode, code set (0 all, 1 no leveling, 2 no nominal), terminals, speed
   localparam logic [10:0] ROWS [16] = '{
      {2'h1, 2'h0, 4'b0001, 3'h1}, {2'h1, 2'h0, 4'b0010, 3'h2},
      {2'h1, 2'h0, 4'b0011, 3'h3}, {2'h1, 2'h0, 4'b0110, 3'h4},
      {2'h1, 2'h0, 4'b0100, 3'h5}, {2'h1, 2'h0, 4'b1000, 3'h6},
      {2'h1, 2'h0, 4'b0000, 3'h0}, {2'h1, 2'h0, 4'b1001, 3'h1},
      {2'h1, 2'h1, 4'b0000, 3'h6}, {2'h1, 2'h1, 4'b1000, 3'h6},
      {2'h2, 2'h0, 4'b1001, 3'h6}, {2'h2, 2'h0, 4'b0001, 3'h1},
      {2'h2, 2'h2, 4'b0010, 3'h2}, {2'h2, 2'h2, 4'b0110, 3'h4},
      {2'h2, 2'h2, 4'b0100, 3'h5}, {2'h2, 2'h2, 4'b1010, 3'h6}};
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, up_dir, down_dir, run, fault, irq;
   logic [3:0] terms, want_terms = 4'h0, insp = 4'h0;
   logic [1:0] want_dir = 2'h0;
   logic lvl_prio = 1'b0, slow = 1'b0;
   lssd_pkg::lssd_speed_type spd;
   int errors = 0, check_count = 0;
   // 250 mhz clock
   always #2 clk_i = ~clk_i;
   lssd_decoder i_lssd_decoder (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .input_terminal_i(terms),
      .up_dir_i(up_dir), .down_dir_i(down_dir), .speed_sel_o(spd), .run_o(run),
      .reference_loss_fault_o(fault), .irq_o(irq));
   lssd_lift_ctrl i_lssd_lift_ctrl (.clk_i(clk_i), .rst_b_i(rst_b_i), .want_terms_i(want_terms),
      .want_dir_i(want_dir), .insp_terms_i(insp), .level_prio_i(lvl_prio), .slow_i(slow),
      .input_terminal_o(terms), .up_dir_o(up_dir), .down_dir_o(down_dir));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic give_verdict();
      $display("counts: checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // compares {irq, fault, run, speed}
   task automatic chk_out(input logic [5:0] exp);
      check_count++;
      if ({irq, fault, run, spd} !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, {irq, fault, run, spd}, exp);
      end
   endtask
   // one apb transfer; the idle edge first keeps psel from being driven twice in a step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         errors++;
         give_verdict();
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk_word(rd, exp);
   endtask
   task automatic setup(input logic [1:0] mode, input logic rl, input logic [31:0] codes);
      apb(1'b1, lssd_pkg::ADDR_CONFIG, {27'h0, rl, 2'h0, mode});
      apb(1'b1, lssd_pkg::ADDR_FUNC, codes);
      apb(1'b1, lssd_pkg::ADDR_IRQ_STAT, 32'h7);
      lvl_prio <= (mode == 2'h2);
      for (int i = 0; i < 4; i++) begin
         insp[i] <= (codes[8*i +: 8] == lssd_pkg::FC_INSPECT);
      end
   endtask
   // the model may lag two edges, the drive one more, the interrupt one more
   task automatic drive(input logic [3:0] t, input logic [1:0] d);
      @(posedge clk_i);
      want_terms <= t;
      want_dir <= d;
      repeat (5) @(posedge clk_i);
      #1;
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk_i);
      rst_b_i <= 1'b1;
      chk_out(6'h00);
      rd_chk(lssd_pkg::ADDR_CONFIG, 32'h11);
      rd_chk(lssd_pkg::ADDR_FUNC, 32'h53515450);
      rd_chk(lssd_pkg::ADDR_IRQ_MASK, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      chk_word({31'h0, err}, 32'h1);
      drive(4'b0101, 2'h0);
      chk_out(6'h03);
      $display("test reset values done");
      foreach (ROWS[i]) begin
         setup(ROWS[i][10:9], 1'b1, CODES[ROWS[i][8:7]]);
         drive(ROWS[i][6:3], 2'h0);
         chk_out({3'h0, ROWS[i][2:0]});
      end
      $display("test decode table done");
      // higher speed wins, leveling input assigned
      setup(2'h1, 1'b1, CODES[0]);
      drive(4'b0001, 2'h1);
      chk_out(6'h09);
      drive(4'b1001, 2'h1);
      chk_out(6'h09);
      drive(4'b1000, 2'h1);
      chk_out(6'h0e);
      drive(4'b0000, 2'h1);
      chk_out(6'h00);
      rd_chk(lssd_pkg::ADDR_IRQ_STAT, 32'h6);
      // a stopped run needs the direction dropped before a new start
      drive(4'b0001, 2'h0);
      chk_out(6'h01);
      drive(4'b0001, 2'h2);
      chk_out(6'h09);
      drive(4'b0001, 2'h3);
      chk_out(6'h01);
      drive(4'b0001, 2'h0);
      apb(1'b1, lssd_pkg::ADDR_IRQ_STAT, 32'h7);
      rd_chk(lssd_pkg::ADDR_IRQ_STAT, 32'h0);
      $display("test high priority done");
      // no leveling input: reference loss then leveling travel
      setup(2'h1, 1'b1, CODES[1]);
      apb(1'b1, lssd_pkg::ADDR_IRQ_MASK, 32'h1);
      drive(4'b0000, 2'h1);
      chk_out(6'h36);
      rd_chk(lssd_pkg::ADDR_STATUS, 32'h26);
      apb(1'b1, lssd_pkg::ADDR_IRQ_STAT, 32'h1);
      drive(4'b0000, 2'h0);
      chk_out(6'h06);
      setup(2'h1, 1'b0, CODES[1]);
      drive(4'b0000, 2'h1);
      chk_out(6'h0e);
      drive(4'b0001, 2'h1);
      chk_out(6'h09);
      drive(4'b0000, 2'h1);
      chk_out(6'h0e);
      drive(4'b0000, 2'h0);
      chk_out(6'h06);
      apb(1'b1, lssd_pkg::ADDR_IRQ_MASK, 32'h0);
      $display("test reference loss done");
      // leveling priority, with and without nominal input, slow controller
      setup(2'h2, 1'b1, CODES[0]);
      drive(4'b0001, 2'h1);
      chk_out(6'h09);
      drive(4'b1001, 2'h1);
      chk_out(6'h0e);
      drive(4'b0000, 2'h1);
      chk_out(6'h00);
      drive(4'b0000, 2'h0);
      slow <= 1'b1;
      setup(2'h2, 1'b1, CODES[2]);
      drive(4'b0010, 2'h1);
      chk_out(6'h0a);
      drive(4'b1010, 2'h1);
      chk_out(6'h0e);
      drive(4'b1010, 2'h0);
      chk_out(6'h06);
      slow <= 1'b0;
      $display("test leveling priority done");
      // reset in mid run restores outputs and settings
      setup(2'h1, 1'b0, CODES[1]);
      drive(4'b0001, 2'h1);
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      chk_out(6'h00);
      @(posedge clk_i);
      rst_b_i <= 1'b1;
      rd_chk(lssd_pkg::ADDR_CONFIG, 32'h11);
      $display("test mid run reset done");
      give_verdict();
   end
endmodule // lssd_decoder_tb_top
